// File: include/shic_pkg.sv
// Constants, field layout, reset words and types of the sync, holdover and input config bank
package shic_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int DAC_W = 10;
  localparam int N_OUT = 6;
  localparam int N_REF = 3;
  localparam int N_CFG = 6;
  // Register numbers carried in the low five bits of each serial word
  localparam logic [4:0] REG_RESET_CTRL = 5'h00;
  localparam logic [4:0] REG_LAST_OUTPUT = 5'h05;
  localparam logic [4:0] REG_SYNC_MODE = 5'h0B;
  localparam logic [4:0] REG_LOCK_PIN = 5'h0C;
  localparam logic [4:0] REG_HOLD_INPUT = 5'h0D;
  localparam logic [4:0] REG_LOSS_TRIP = 5'h0E;
  localparam logic [4:0] REG_MANUAL_DAC = 5'h0F;
  localparam logic [4:0] REG_XTAL = 5'h10;
  localparam logic [4:0] REG_READBACK = 5'h1F;
  // Storage slots, register number minus REG_SYNC_MODE
  localparam int CFG_SYNC = 0;
  localparam int CFG_LOCK = 1;
  localparam int CFG_HOLD = 2;
  localparam int CFG_LOSS = 3;
  localparam int CFG_DAC = 4;
  localparam int DEVICE_RESET_BIT = 17;
  localparam int READBACK_SEL_LSB = 16;
  // Field positions
  localparam int SYNC_ENABLE_BIT = 26;
  localparam int EXCLUDE_LSB = 20;
  localparam int SYNC_OUT_SEL_LSB = 18;
  localparam int SYNC_QUALIFY_ENABLE_BIT = 17;
  localparam int SYNC_POL_BIT = 16;
  localparam int SYNC_AUTO_BIT = 15;
  localparam int SYNC_TYPE_LSB = 12;
  localparam int LOCK_SEL_LSB = 27;
  localparam int SYNC_LOOP2_BIT = 23;
  localparam int SYNC_LOOP1_BIT = 22;
  localparam int TRACK_BIT = 8;
  localparam int HO_MODE_LSB = 6;
  localparam int HO_PIN_SEL_LSB = 27;
  localparam int UNLOCK_BLOCK_BIT = 15;
  localparam int REF_POLICY_LSB = 9;
  localparam int SEL_INVERT_BIT = 8;
  localparam int REF_USABLE_LSB = 5;
  localparam int INACTIVITY_TIMEOUT_LSB = 30;
  localparam int LOS_ENABLE_BIT = 28;
  localparam int HIGH_TRIP_LSB = 14;
  localparam int LOW_TRIP_LSB = 6;
  localparam int RAIL_ENABLE_BIT = 5;
  localparam int DAC_CODE_LSB = 22;
  localparam int DAC_OVERRIDE_BIT = 20;
  localparam int EXIT_COUNT_LSB = 6;
  localparam int FORCE_HO_BIT = 5;
  // Mode and pin codes
  localparam logic [1:0] HO_MODE_ENABLE = 2'h2;
  localparam logic [2:0] POLICY_MANUAL = 3'h3;
  localparam logic [2:0] POLICY_AUTO = 3'h4;
  localparam logic [2:0] SYNC_TYPE_OUT_MIN = 3'h3;
  localparam logic [1:0] SYNC_OUT_LOW = 2'h0;
  localparam logic [1:0] SYNC_OUT_HIGH = 2'h1;
  localparam logic [1:0] SYNC_OUT_LOOP1 = 2'h2;
  localparam logic [1:0] SYNC_OUT_LOS = 2'h3;
  localparam logic [4:0] PIN_LOOP1 = 5'h01;
  localparam logic [4:0] PIN_LOOP2 = 5'h02;
  localparam logic [4:0] PIN_BOTH = 5'h03;
  localparam logic [4:0] PIN_HOLDOVER = 5'h04;
  localparam logic [4:0] PIN_READBACK = 5'h07;
  localparam logic [5:0] TRIP_FULL = 6'h3F;
  // Inactivity times per timeout code, least times rounded up to whole cycles
  localparam int LOS_T0_NS = 1200;
  localparam int LOS_T1_NS = 600;
  localparam int LOS_T2_NS = 300;
  localparam int LOS_T3_NS = 2400;
  localparam int LOS_T0_CYC = (LOS_T0_NS * CLK_MHZ + 999) / 1000;
  localparam int LOS_T1_CYC = (LOS_T1_NS * CLK_MHZ + 999) / 1000;
  localparam int LOS_T2_CYC = (LOS_T2_NS * CLK_MHZ + 999) / 1000;
  localparam int LOS_T3_CYC = (LOS_T3_NS * CLK_MHZ + 999) / 1000;
  localparam int LOS_CNT_W = 12;
  // Reset words and writable bits, slot 0 (register 11) in the low word
  localparam logic [N_CFG-1:0][31:0] REG_RESET_WORDS = {
    32'h0000_0000, 32'h8000_8000, 32'h1200_0000,
    32'h3B02_06E0, 32'h1B00_0180, 32'h0581_1000};
  localparam logic [N_CFG-1:0][31:0] REG_WRITE_MASKS = {
    32'hC000_0000, 32'hFFDF_FFE0, 32'hD77F_CFE0,
    32'hFF77_FFE0, 32'hFFC0_01C0, 32'hFFFF_F020};

  typedef enum logic [1:0] {HO_TRACK, HO_HOLD, HO_EXIT} shic_ho_state_e;

  typedef struct packed {
    logic sync_enable;
    logic [5:0] sync_exclude;
    logic [1:0] sync_out_sel;
    logic sync_qualify;
    logic sync_polarity;
    logic sync_auto;
    logic [2:0] sync_type;
    logic [4:0] lock_sel;
    logic sync_until_loop2;
    logic sync_until_loop1;
    logic track;
    logic [1:0] ho_mode;
    logic [4:0] ho_pin_sel;
    logic unlock_block;
    logic [2:0] ref_policy;
    logic sel_invert;
    logic [2:0] ref_usable;
    logic [1:0] inactivity_timeout;
    logic los_enable;
    logic [5:0] high_trip;
    logic [5:0] low_trip;
    logic rail_enable;
    logic [9:0] dac_code;
    logic dac_override;
    logic [13:0] exit_count;
    logic force_ho;
  } shic_cfg_s;
endpackage

// File: rtl/shic_config_bank.sv
// Serial-programmed sync, holdover, reference select and DAC configuration bank
`timescale 1ns/1ps
module shic_config_bank #(
  parameter int LOS_CNT_W = shic_pkg::LOS_CNT_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_ser_le,
  input wire logic i_sync_pin,
  input wire logic i_status0_pin,
  input wire logic i_status1_pin,
  input wire logic [2:0] i_ref_activity,
  input wire logic i_loop1_lock,
  input wire logic i_loop2_lock,
  input wire logic i_pdf_tick,
  input wire logic i_qual_tick,
  input wire logic [9:0] i_vtune_code,
  output logic o_sync_pin,
  output logic o_sync_pin_oe,
  output logic o_ld_pin,
  output logic o_holdover_pin,
  output logic [5:0] o_sync_active,
  output logic o_holdover,
  output logic o_loop1_unlock,
  output logic [9:0] o_dac_value,
  output logic [1:0] o_ref_sel,
  output logic [2:0] o_los
);
  localparam int N_PIN = 9;
  // Sync pin rests high on its pull-up; a filter that starts low would fake a sync after reset
  localparam logic [N_PIN-1:0] PIN_IDLE = 9'h008;

  // The counter must reach the longest inactivity time
  if (LOS_CNT_W < 2 || LOS_CNT_W > 16 || (1 << LOS_CNT_W) <= shic_pkg::LOS_T3_CYC) begin
    $error("LOS_CNT_W too small or too large for the inactivity times");
  end

  logic [N_PIN-1:0] pin_s1, pin_s2, pin_s3, pin_f, pin_q;
  logic [31:0] shift_reg, rb_shift;
  logic [shic_pkg::N_CFG-1:0][31:0] cfg_mem;
  logic sync_pend;
  logic loop1_q;
  logic [13:0] ho_cnt;
  shic_pkg::shic_ho_state_e ho_state, next_state;
  shic_pkg::shic_cfg_s cfg;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  // Field extraction from the stored words
  function automatic shic_pkg::shic_cfg_s decode(input logic [5:0][31:0] m);
    shic_pkg::shic_cfg_s c;
    c.sync_enable = m[shic_pkg::CFG_SYNC][shic_pkg::SYNC_ENABLE_BIT];
    c.sync_exclude = m[shic_pkg::CFG_SYNC][shic_pkg::EXCLUDE_LSB +: 6];
    c.sync_out_sel = m[shic_pkg::CFG_SYNC][shic_pkg::SYNC_OUT_SEL_LSB +: 2];
    c.sync_qualify = m[shic_pkg::CFG_SYNC][shic_pkg::SYNC_QUALIFY_ENABLE_BIT];
    c.sync_polarity = m[shic_pkg::CFG_SYNC][shic_pkg::SYNC_POL_BIT];
    c.sync_auto = m[shic_pkg::CFG_SYNC][shic_pkg::SYNC_AUTO_BIT];
    c.sync_type = m[shic_pkg::CFG_SYNC][shic_pkg::SYNC_TYPE_LSB +: 3];
    c.lock_sel = m[shic_pkg::CFG_LOCK][shic_pkg::LOCK_SEL_LSB +: 5];
    c.sync_until_loop2 = m[shic_pkg::CFG_LOCK][shic_pkg::SYNC_LOOP2_BIT];
    c.sync_until_loop1 = m[shic_pkg::CFG_LOCK][shic_pkg::SYNC_LOOP1_BIT];
    c.track = m[shic_pkg::CFG_LOCK][shic_pkg::TRACK_BIT];
    c.ho_mode = m[shic_pkg::CFG_LOCK][shic_pkg::HO_MODE_LSB +: 2];
    c.ho_pin_sel = m[shic_pkg::CFG_HOLD][shic_pkg::HO_PIN_SEL_LSB +: 5];
    c.unlock_block = m[shic_pkg::CFG_HOLD][shic_pkg::UNLOCK_BLOCK_BIT];
    c.ref_policy = m[shic_pkg::CFG_HOLD][shic_pkg::REF_POLICY_LSB +: 3];
    c.sel_invert = m[shic_pkg::CFG_HOLD][shic_pkg::SEL_INVERT_BIT];
    c.ref_usable = m[shic_pkg::CFG_HOLD][shic_pkg::REF_USABLE_LSB +: 3];
    c.inactivity_timeout = m[shic_pkg::CFG_LOSS][shic_pkg::INACTIVITY_TIMEOUT_LSB +: 2];
    c.los_enable = m[shic_pkg::CFG_LOSS][shic_pkg::LOS_ENABLE_BIT];
    c.high_trip = m[shic_pkg::CFG_LOSS][shic_pkg::HIGH_TRIP_LSB +: 6];
    c.low_trip = m[shic_pkg::CFG_LOSS][shic_pkg::LOW_TRIP_LSB +: 6];
    c.rail_enable = m[shic_pkg::CFG_LOSS][shic_pkg::RAIL_ENABLE_BIT];
    c.dac_code = m[shic_pkg::CFG_DAC][shic_pkg::DAC_CODE_LSB +: shic_pkg::DAC_W];
    c.dac_override = m[shic_pkg::CFG_DAC][shic_pkg::DAC_OVERRIDE_BIT];
    c.exit_count = m[shic_pkg::CFG_DAC][shic_pkg::EXIT_COUNT_LSB +: 14];
    c.force_ho = m[shic_pkg::CFG_DAC][shic_pkg::FORCE_HO_BIT];
    return c;
  endfunction

  // Readback image; the DAC field shows the live code, not the written one
  function automatic logic [31:0] read_word(input logic [4:0] sel,
                                            input logic [5:0][31:0] m,
                                            input logic [9:0] dac);
    logic [31:0] w;
    logic [2:0] idx;
    idx = 3'(sel - shic_pkg::REG_SYNC_MODE);
    w = 32'h0000_0000;
    if (sel >= shic_pkg::REG_SYNC_MODE && sel <= shic_pkg::REG_XTAL) begin
      w = m[idx];
    end
    if (sel == shic_pkg::REG_MANUAL_DAC) begin
      w[shic_pkg::DAC_CODE_LSB +: shic_pkg::DAC_W] = dac;
    end
    return w;
  endfunction

  // Shared decode of the lock pin and holdover pin selectors
  function automatic logic pin_mux(input logic [4:0] sel, input logic l1, input logic l2,
                                   input logic ho, input logic rb);
    case (sel)
      shic_pkg::PIN_LOOP1: return l1;
      shic_pkg::PIN_LOOP2: return l2;
      shic_pkg::PIN_BOTH: return l1 & l2;
      shic_pkg::PIN_HOLDOVER: return ho;
      shic_pkg::PIN_READBACK: return rb;
      default: return 1'b0;
    endcase
  endfunction

  // Inactivity limit in cycles for each timeout code
  function automatic logic [15:0] los_limit(input logic [1:0] code);
    case (code)
      2'h0: return 16'(shic_pkg::LOS_T0_CYC);
      2'h1: return 16'(shic_pkg::LOS_T1_CYC);
      2'h2: return 16'(shic_pkg::LOS_T2_CYC);
      default: return 16'(shic_pkg::LOS_T3_CYC);
    endcase
  endfunction

  // Preferred input if usable, otherwise the lowest usable one
  function automatic logic [1:0] pick(input logic [2:0] ok, input logic [1:0] pref);
    if (pref != 2'h3 && ok[pref]) begin
      return pref;
    end
    if (ok[0]) begin
      return 2'h0;
    end
    if (ok[1]) begin
      return 2'h1;
    end
    if (ok[2]) begin
      return 2'h2;
    end
    return pref;
  endfunction

  // Pin conditioning: a change counts once the second and third stages agree
  wire [N_PIN-1:0] pin_raw = {i_ref_activity, i_status1_pin, i_status0_pin, i_sync_pin,
                              i_ser_le, i_ser_data, i_ser_clk};
  wire [N_PIN-1:0] next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      pin_s3 <= PIN_IDLE;
      pin_f <= PIN_IDLE;
      pin_q <= PIN_IDLE;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= next_pin_f;
      pin_q <= pin_f;
    end
  end

  // Serial port events
  wire ser_le = pin_f[2];
  wire ser_rise = pin_f[0] & ~pin_q[0] & ~ser_le;
  wire ser_fall = ~pin_f[0] & pin_q[0] & ~ser_le;
  wire le_rise = ser_le & ~pin_q[2];
  wire [4:0] wr_addr = shift_reg[4:0];
  wire [2:0] cfg_idx = 3'(wr_addr - shic_pkg::REG_SYNC_MODE);
  wire wr_cfg = le_rise && wr_addr >= shic_pkg::REG_SYNC_MODE && wr_addr <= shic_pkg::REG_XTAL;
  wire soft_rst = le_rise && wr_addr == shic_pkg::REG_RESET_CTRL &&
                  shift_reg[shic_pkg::DEVICE_RESET_BIT];
  wire rb_load = le_rise && wr_addr == shic_pkg::REG_READBACK;

  // Shift in MSB first while the latch line is low; readback shifts out on falling edges
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_reg <= 32'h0000_0000;
      rb_shift <= 32'h0000_0000;
    end else begin
      if (ser_rise) begin
        shift_reg <= {shift_reg[30:0], pin_f[1]};
      end
      if (rb_load) begin
        rb_shift <= read_word(shift_reg[shic_pkg::READBACK_SEL_LSB +: 5], cfg_mem, o_dac_value);
      end else if (ser_fall) begin
        rb_shift <= {rb_shift[30:0], 1'b0};
      end
    end
  end

  // Field storage; the reset bit reloads every default at once
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_mem <= shic_pkg::REG_RESET_WORDS;
    end else if (soft_rst) begin
      cfg_mem <= shic_pkg::REG_RESET_WORDS;
    end else if (wr_cfg) begin
      cfg_mem[cfg_idx] <= shift_reg & shic_pkg::REG_WRITE_MASKS[cfg_idx];
    end
  end

  assign cfg = decode(cfg_mem);

  // Sync control; an automatic request waits for the qualifying tick, set beats clear
  wire sync_in_act = pin_f[3] ^ cfg.sync_polarity;
  wire auto_hit = le_rise && wr_addr <= shic_pkg::REG_LAST_OUTPUT && cfg.sync_auto;
  wire hold_req = (cfg.sync_until_loop2 & ~i_loop2_lock) |
                  (cfg.sync_until_loop1 & ~i_loop1_lock);
  wire sync_apply = ~cfg.sync_qualify | i_qual_tick;
  wire sync_now = cfg.sync_enable & (sync_in_act | sync_pend | hold_req);
  wire next_sync_pend = auto_hit | (sync_pend & ~sync_apply);
  wire [5:0] next_sync_active = sync_apply ? ({6{sync_now}} & ~cfg.sync_exclude)
                                           : o_sync_active;
  wire next_sync_pin = (cfg.sync_out_sel == shic_pkg::SYNC_OUT_HIGH) ? 1'b1 :
                       (cfg.sync_out_sel == shic_pkg::SYNC_OUT_LOOP1) ? i_loop1_lock :
                       (cfg.sync_out_sel == shic_pkg::SYNC_OUT_LOS) ? |o_los : 1'b0;

  // DAC and rail trips; holdover freezes the code unless override is on
  wire [9:0] next_dac = cfg.dac_override ? cfg.dac_code :
                        (cfg.track && ho_state == shic_pkg::HO_TRACK) ? i_vtune_code :
                        o_dac_value;
  wire rail_hi = o_dac_value[9:4] >= (shic_pkg::TRIP_FULL - cfg.high_trip);
  wire rail_lo = o_dac_value[9:4] <= cfg.low_trip;
  wire rail_trip = cfg.rail_enable & (rail_hi | rail_lo);

  // Holdover entry conditions
  wire ho_allowed = cfg.ho_mode == shic_pkg::HO_MODE_ENABLE;
  wire lock_fell = loop1_q & ~i_loop1_lock;
  wire ho_enter = cfg.force_ho |
                  (ho_allowed & ((lock_fell & ~cfg.unlock_block) | rail_trip));
  wire exit_done = ho_cnt >= cfg.exit_count;

  // Holdover state machine: lock must stay good for the exit count before tracking resumes
  always_comb begin
    next_state = ho_state;
    case (ho_state)
      shic_pkg::HO_TRACK: begin
        if (ho_enter) begin
          next_state = shic_pkg::HO_HOLD;
        end
      end
      shic_pkg::HO_HOLD: begin
        if (!cfg.force_ho && !rail_trip && i_loop1_lock) begin
          next_state = shic_pkg::HO_EXIT;
        end
      end
      shic_pkg::HO_EXIT: begin
        if (ho_enter || !i_loop1_lock) begin
          next_state = shic_pkg::HO_HOLD;
        end else if (exit_done) begin
          next_state = shic_pkg::HO_TRACK;
        end
      end
      default: next_state = shic_pkg::HO_TRACK;
    endcase
  end

  wire stay_exit = ho_state == shic_pkg::HO_EXIT && next_state == shic_pkg::HO_EXIT;
  wire [13:0] next_ho_cnt = stay_exit ? (i_pdf_tick ? 14'(ho_cnt + 14'h0001) : ho_cnt)
                                      : 14'h0000;

  // Inactivity detection per reference input
  wire [LOS_CNT_W-1:0] los_lim = LOS_CNT_W'(los_limit(cfg.inactivity_timeout));
  logic [2:0] los_vec;
  for (genvar g = 0; g < shic_pkg::N_REF; g++) begin : g_los
    logic [LOS_CNT_W-1:0] idle_cnt;
    logic lost;
    wire act_edge = pin_f[6 + g] ^ pin_q[6 + g];
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        idle_cnt <= '0;
        lost <= 1'b0;
      end else if (!cfg.los_enable || act_edge) begin
        idle_cnt <= '0;
        lost <= 1'b0;
      end else if (idle_cnt >= los_lim) begin
        lost <= 1'b1;
      end else begin
        idle_cnt <= LOS_CNT_W'(idle_cnt + 1'b1);
      end
    end
    assign los_vec[g] = lost;
  end

  // Reference choice: manual from status pins, fixed, or automatic among live inputs
  wire [1:0] man_idx = {pin_f[5], pin_f[4]} ^ {2{cfg.sel_invert}};
  wire [1:0] next_ref = (cfg.ref_policy == shic_pkg::POLICY_MANUAL) ?
                          pick(cfg.ref_usable, man_idx) :
                        (cfg.ref_policy == shic_pkg::POLICY_AUTO) ?
                          pick(cfg.ref_usable & ~los_vec, o_ref_sel) :
                        (cfg.ref_policy < shic_pkg::POLICY_MANUAL) ?
                          pick(cfg.ref_usable, cfg.ref_policy[1:0]) : o_ref_sel;

  // Registered state and outputs
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ho_state <= shic_pkg::HO_TRACK;
      ho_cnt <= 14'h0000;
      loop1_q <= 1'b0;
      sync_pend <= 1'b0;
      o_sync_active <= 6'h00;
      o_sync_pin <= 1'b0;
      o_sync_pin_oe <= 1'b0;
      o_ld_pin <= 1'b0;
      o_holdover_pin <= 1'b0;
      o_holdover <= 1'b0;
      o_loop1_unlock <= 1'b0;
      o_dac_value <= shic_pkg::REG_RESET_WORDS[shic_pkg::CFG_DAC][31:22];
      o_ref_sel <= 2'h0;
      o_los <= 3'h0;
    end else begin
      ho_state <= next_state;
      ho_cnt <= next_ho_cnt;
      loop1_q <= i_loop1_lock;
      sync_pend <= next_sync_pend;
      o_sync_active <= next_sync_active;
      o_sync_pin <= next_sync_pin;
      o_sync_pin_oe <= cfg.sync_type >= shic_pkg::SYNC_TYPE_OUT_MIN;
      o_ld_pin <= pin_mux(cfg.lock_sel, i_loop1_lock, i_loop2_lock, o_holdover,
                          rb_shift[31]);
      o_holdover_pin <= pin_mux(cfg.ho_pin_sel, i_loop1_lock, i_loop2_lock, o_holdover,
                                rb_shift[31]);
      o_holdover <= next_state != shic_pkg::HO_TRACK;
      o_loop1_unlock <= rail_trip;
      o_dac_value <= next_dac;
      o_ref_sel <= next_ref;
      o_los <= los_vec;
    end
  end

  // Checks
  sequence s_loop_unlocked_sync(logic want, logic lock);
    want && !lock && cfg.sync_enable && !cfg.sync_qualify && !cfg.sync_exclude[0];
  endsequence

  AST_EXCLUDE: assert property (!$past(cfg.sync_qualify) |->
    (o_sync_active & $past(cfg.sync_exclude)) == 6'h00) else $error("excluded output synced");
  AST_AUTO_SYNC: assert property ($rose(sync_pend) |-> $past(cfg.sync_auto))
    else $error("sync started by write with auto sync off");
  AST_HOLD_LOOP2: assert property (s_loop_unlocked_sync(cfg.sync_until_loop2, i_loop2_lock)
    |=> o_sync_active[0]) else $error("sync not held until loop 2 lock");
  AST_HOLD_LOOP1: assert property (s_loop_unlocked_sync(cfg.sync_until_loop1, i_loop1_lock)
    |=> o_sync_active[0]) else $error("sync not held until loop 1 lock");
  AST_TRACK: assert property (!cfg.dac_override && cfg.track && ho_state == shic_pkg::HO_TRACK
    |=> o_dac_value == $past(i_vtune_code)) else $error("DAC not tracking");
  AST_OVERRIDE: assert property (cfg.dac_override |=> o_dac_value == $past(cfg.dac_code))
    else $error("DAC override ignored");
  AST_FORCE_HO: assert property (cfg.force_ho |=> o_holdover)
    else $error("forced holdover not held");
  AST_EXIT_COUNT: assert property ($fell(o_holdover) |->
    $past(ho_cnt) >= $past(cfg.exit_count) && $past(i_loop1_lock))
    else $error("holdover left before exit count");
  AST_LOS_OFF: assert property (!cfg.los_enable |=> ##1 o_los == 3'h0)
    else $error("loss of signal flagged while disabled");
  AST_RAIL: assert property (o_loop1_unlock |-> $past(cfg.rail_enable))
    else $error("rail unlock without rail detection");
  AST_REF_USABLE: assert property ($past(cfg.ref_policy == shic_pkg::POLICY_MANUAL &&
    |cfg.ref_usable) |-> (($past(cfg.ref_usable) >> o_ref_sel) & 3'h1) == 3'h1)
    else $error("unusable reference chosen");
endmodule

// File: verification/shic_config_bank_bench.sv
// Self-checking bench for the sync, holdover and input config bank
`timescale 1ns/1ps
module shic_config_bank_bench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ser_clk = 1'b0, ser_data = 1'b0, ser_le = 1'b0, sync_pin = 1'b1;
  logic [1:0] status = 2'h0;
  logic [2:0] ref_act = 3'h0, act_en = 3'h7, los;
  logic loop1 = 1'b1, loop2 = 1'b1, pdf_tick = 1'b0, pdf_en = 1'b0, qual = 1'b0;
  logic [9:0] vtune = 10'h000, code, dac;
  logic sync_out, sync_oe, ld_pin, ho_pin, holdover, unlock;
  logic [5:0] sync_act;
  logic [1:0] ref_sel;
  logic [3:0] slow = 4'h0;
  int n_fail = 0, n_tests = 0;

  shic_config_bank i_shic_config_bank (.i_core_clk(core_clk), .i_rst_b(rst_b),
    .i_ser_clk(ser_clk), .i_ser_data(ser_data), .i_ser_le(ser_le), .i_sync_pin(sync_pin),
    .i_status0_pin(status[0]), .i_status1_pin(status[1]), .i_ref_activity(ref_act),
    .i_loop1_lock(loop1), .i_loop2_lock(loop2), .i_pdf_tick(pdf_tick), .i_qual_tick(qual),
    .i_vtune_code(vtune), .o_sync_pin(sync_out), .o_sync_pin_oe(sync_oe), .o_ld_pin(ld_pin),
    .o_holdover_pin(ho_pin), .o_sync_active(sync_act), .o_holdover(holdover),
    .o_loop1_unlock(unlock), .o_dac_value(dac), .o_ref_sel(ref_sel), .o_los(los));

  always #10 core_clk = ~core_clk;

  // Slow toggles so the pin filter keeps every activity edge
  always @(posedge core_clk) begin
    #2;
    slow <= slow + 4'h1;
    if (slow[2:0] == 3'h0) ref_act <= ref_act ^ act_en;
    pdf_tick <= pdf_en;
  end

  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Outputs that a sync reaches under a given sync control word
  function automatic logic [31:0] sync_exp(input logic [31:0] w);
    return {26'h000_0000, ~w[25:20]};
  endfunction

  // Phases of five cycles stay clear of the three-flop sync and filter
  task ser_write(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      tick(5);
      ser_clk = 1'b1;
      tick(5);
      ser_clk = 1'b0;
    end
    ser_le = 1'b1;
    tick(6);
    ser_le = 1'b0;
    tick(10);
  endtask

  task complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog well beyond the fourteen serial words and the holdover exit wait
  initial begin
    #500_000;
    n_fail++;
    complete_run();
  end

  initial begin
    void'($urandom(67));
    tick(5);
    // Tracking starts at once, so the default code only shows while reset is held
    check("dac", 32'h0000_0200, dac);
    rst_b = 1'b1;
    tick(10);
    check("dac", 32'h0000_0000, dac);
    check("ref_sel", 32'd0, ref_sel);
    check("holdover", 32'd0, holdover);
    vtune = 10'($urandom);
    tick(6);
    check("dac", vtune, dac);
    sync_pin = 1'b0;
    tick(10);
    check("sync_act", 32'h27, sync_act);
    sync_pin = 1'b1;
    tick(10);
    check("sync_act", 32'h0, sync_act);
    status = 2'h1;
    tick(10);
    check("ref_sel", 32'd1, ref_sel);
    ser_write(32'h3B02_06AD);
    check("ref_sel", 32'd0, ref_sel);
    ser_write(32'h3B02_07ED);
    check("ref_sel", 32'd2, ref_sel);
    act_en = 3'h6;
    tick(50);
    check("los", 32'h0, los);
    tick(40);
    check("los", 32'h1, los);
    ser_write(32'h0200_000E);
    check("los", 32'h0, los);
    act_en = 3'h7;
    ser_write(32'h1200_000E);
    check("los", 32'h0, los);
    // Random manual codes, exit count kept at three ticks
    repeat (2) begin
      code = 10'($urandom);
      ser_write({code, 2'h1, 14'h0003, 6'h0F});
      check("dac", code, dac);
    end
    // Read register 15 back on the holdover pin: the DAC field shows the live code
    ser_write(32'h000F_001F);
    for (int i = 9; i >= 0; i--) begin
      check("ho_pin", code[i], ho_pin);
      ser_clk = 1'b1;
      tick(5);
      ser_clk = 1'b0;
      tick(8);
    end
    ser_write({code, 2'h1, 14'h0003, 6'h2F});
    check("holdover", 32'd1, holdover);
    ser_write({code, 2'h1, 14'h0003, 6'h0F});
    check("holdover", 32'd1, holdover);
    pdf_en = 1'b1;
    tick(8);
    check("holdover", 32'd0, holdover);
    ser_write(32'h1B40_018C);
    loop1 = 1'b0;
    tick(6);
    check("sync_act", 32'h27, sync_act);
    check("ld_pin", 32'd0, ld_pin);
    check("holdover", 32'd1, holdover);
    loop1 = 1'b1;
    tick(6);
    check("sync_act", 32'h0, sync_act);
    check("ld_pin", 32'd1, ld_pin);
    // Qualified auto sync: a write to an output register waits for the qualifying tick
    ser_write(32'h0587_B00B);
    check("sync_out", 32'h1, sync_out);
    check("sync_oe", 32'h1, sync_oe);
    ser_write(32'h0000_0003);
    check("sync_act", 32'h0, sync_act);
    qual = 1'b1;
    tick(1);
    qual = 1'b0;
    check("sync_act", sync_exp(32'h0587_B00B), sync_act);
    tick(3);
    check("sync_act", sync_exp(32'h0587_B00B), sync_act);
    qual = 1'b1;
    tick(1);
    qual = 1'b0;
    check("sync_act", 32'h0, sync_act);
    // A trip point at full scale forces loop 1 unlocked and enters holdover
    ser_write(32'h120F_C02E);
    check("unlock", 32'h1, unlock);
    check("holdover", 32'h1, holdover);
    ser_write(32'h0002_0000);
    check("unlock", 32'h0, unlock);
    check("holdover", 32'h1, holdover);
    tick(600);
    check("holdover", 32'h0, holdover);
    check("dac", vtune, dac);
    complete_run();
  end
endmodule
